// ### gef_regs.svh
`ifndef GEF_REGS_SVH
`define GEF_REGS_SVH

// port widths
`define GEF_E_W      8
`define GEF_F_W      7

// register indices; the byte address is four times the index
`define GEF_IDX_E_DATA 8'h08
`define GEF_IDX_F_DATA 8'h09
`define GEF_IDX_E_DIR  8'h0c
`define GEF_IDX_F_DIR  8'h0d

// reset values
`define GEF_E_DIR_RST  8'h00
`define GEF_F_DIR_RST  7'h00
`define GEF_E_OUT_RST  8'h00
`define GEF_F_OUT_RST  7'h00
`define GEF_E_OEN_RST  8'hff
`define GEF_F_OEN_RST  7'h7f
`define GEF_RD_RST     32'h0000_0000
`define GEF_RS_RST     2'h0

// pin positions on the east port
`define GEF_E_SCK      7
`define GEF_E_MOSI     6
`define GEF_E_MISO     5
`define GEF_E_SS       4
`define GEF_E_RXD      1
`define GEF_E_TXD      0

`endif

// ### gef_pkg.sv
`default_nettype none
`include "gef_regs.svh"

package gef_pkg;

	typedef enum logic {
		GEF_WAIT = 1'b0,
		GEF_ACK  = 1'b1
	} gef_bus_e;

	typedef struct packed {
		logic [`GEF_E_W-1:0] east_latch;
		logic [`GEF_F_W-1:0] fox_latch;
		logic [`GEF_E_W-1:0] east_dir;
		logic [`GEF_F_W-1:0] fox_dir;
		logic [`GEF_E_W-1:0] east_out;
		logic [`GEF_E_W-1:0] east_oe_n;
		logic [`GEF_E_W-1:0] east_lvl;
		logic [`GEF_F_W-1:0] fox_out;
		logic [`GEF_F_W-1:0] fox_oe_n;
		logic [`GEF_F_W-1:0] fox_lvl;
		gef_bus_e            bus;
		logic [31:0]         rdata;
		logic                slverr;
	} gef_state_s;

endpackage

`default_nettype wire

// ### gef_ports.sv
`timescale 1ns/1ps
`default_nettype none
`include "gef_regs.svh"

// Overview of operation
// - eight software read/write data latch bits for the east port.
// - east direction one drives the latch onto the pin, zero leaves it floating.
// - reset clears all east direction bits, every east pin an input.
// - east data read gives latch where direction is one, pin level where zero.
// - latch writes always land whatever the direction; input pins read unaffected.
// - east pin 7 is serial clock, input as slave, output as master, else gpio.
// - east pin 6 is master-out slave-in while sync serial is on, else gpio.
// - east pin 5 is master-in slave-out while sync serial is on, else gpio.
// - east pin 4 is slave select input only in slave mode; direction ignored there.
// - claimed east pins take direction from the peripheral; reads still follow direction bits.
// - east pins 3 and 2 are timer A channels 1 and 0 per select field.
// - east pin 1 is async serial receive input while async serial is on.
// - east pin 0 is async serial transmit output while async serial is on.
// - seven fox data latch bits, untouched by reset.
// - fox pins 3 to 0 are timer A channels 5 to 2 per select field.
// - fox pins 5 and 4 are timer B channels 1 and 0 per select field.
// - fox direction one enables the output buffer, zero disables it.
// - reset clears all seven fox direction bits.
// - fox data read gives latch where direction is one, pin where zero.
// - timer-claimed fox pins take direction from the timer; reads follow direction bits.
module gef_ports
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  east_pin_in,
	output logic      [7:0]  east_pin_out,
	output logic      [7:0]  east_pin_oe_n,
	output logic      [7:0]  east_pin_level,
	input  wire logic [6:0]  fox_pin_in,
	output logic      [6:0]  fox_pin_out,
	output logic      [6:0]  fox_pin_oe_n,
	output logic      [6:0]  fox_pin_level,
	input  wire logic        sync_serial_on,
	input  wire logic        sync_serial_master,
	input  wire logic        sync_serial_clk_out,
	input  wire logic        sync_serial_mosi_out,
	input  wire logic        sync_serial_miso_out,
	input  wire logic        async_serial_on,
	input  wire logic        async_serial_tx_out,
	input  wire logic [11:0] timer_a_chan_edge_level_sel,
	input  wire logic [5:0]  timer_a_chan_oe,
	input  wire logic [5:0]  timer_a_chan_out,
	input  wire logic [3:0]  timer_b_chan_edge_level_sel,
	input  wire logic [1:0]  timer_b_chan_oe,
	input  wire logic [1:0]  timer_b_chan_out
);
	import gef_pkg::*;

	logic [1:0]          rs;
	logic                rst_q;
	gef_state_s          st;
	gef_state_s          next_st;
	logic [5:0]          ta_own;
	logic [1:0]          tb_own;
	logic [7:0]          e_claim;
	logic [7:0]          e_poe;
	logic [7:0]          e_pout;
	logic [6:0]          f_claim;
	logic [6:0]          f_poe;
	logic [6:0]          f_pout;
	logic [7:0]          e_drv;
	logic [7:0]          e_val;
	logic [6:0]          f_drv;
	logic [6:0]          f_val;
	logic [7:0]          e_rd;
	logic [6:0]          f_rd;
	logic [7:0]          idx;
	logic                hit;
	logic [31:0]         rd_word;
	logic                wr_ok;

	// reset release through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rs <= `GEF_RS_RST;
		end else begin
			rs <= {rs[0], 1'b1};
		end
	end
	assign rst_q = rs[1];

	// a timer channel owns its pin when its edge/level field is non-zero
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_ta
			assign ta_own[gi] = |timer_a_chan_edge_level_sel[2*gi+1:2*gi];
		end
		for (gi = 0; gi < 2; gi++) begin : g_tb
			assign tb_own[gi] = |timer_b_chan_edge_level_sel[2*gi+1:2*gi];
		end
	endgenerate

	// east pin ownership by the serial blocks and timer A
	assign e_claim[`GEF_E_SCK]  = sync_serial_on;
	assign e_poe[`GEF_E_SCK]    = sync_serial_master;
	assign e_pout[`GEF_E_SCK]   = sync_serial_clk_out;
	assign e_claim[`GEF_E_MOSI] = sync_serial_on;
	assign e_poe[`GEF_E_MOSI]   = sync_serial_master;
	assign e_pout[`GEF_E_MOSI]  = sync_serial_mosi_out;
	assign e_claim[`GEF_E_MISO] = sync_serial_on;
	assign e_poe[`GEF_E_MISO]   = ~sync_serial_master;
	assign e_pout[`GEF_E_MISO]  = sync_serial_miso_out;
	assign e_claim[`GEF_E_SS]   = sync_serial_on & ~sync_serial_master;
	assign e_poe[`GEF_E_SS]     = 1'b0;
	assign e_pout[`GEF_E_SS]    = 1'b0;
	assign e_claim[3:2]         = ta_own[1:0];
	assign e_poe[3:2]           = timer_a_chan_oe[1:0];
	assign e_pout[3:2]          = timer_a_chan_out[1:0];
	assign e_claim[`GEF_E_RXD]  = async_serial_on;
	assign e_poe[`GEF_E_RXD]    = 1'b0;
	assign e_pout[`GEF_E_RXD]   = 1'b0;
	assign e_claim[`GEF_E_TXD]  = async_serial_on;
	assign e_poe[`GEF_E_TXD]    = 1'b1;
	assign e_pout[`GEF_E_TXD]   = async_serial_tx_out;

	// fox pin ownership by the two timers; pin 6 is plain gpio
	assign f_claim[3:0] = ta_own[5:2];
	assign f_poe[3:0]   = timer_a_chan_oe[5:2];
	assign f_pout[3:0]  = timer_a_chan_out[5:2];
	assign f_claim[5:4] = tb_own;
	assign f_poe[5:4]   = timer_b_chan_oe;
	assign f_pout[5:4]  = timer_b_chan_out;
	assign f_claim[6]   = 1'b0;
	assign f_poe[6]     = 1'b0;
	assign f_pout[6]    = 1'b0;

	// claimed pins ignore the direction bits
	assign e_drv = (e_claim & e_poe) | (~e_claim & st.east_dir);
	assign e_val = (e_claim & e_pout) | (~e_claim & st.east_latch);
	assign f_drv = (f_claim & f_poe) | (~f_claim & st.fox_dir);
	assign f_val = (f_claim & f_pout) | (~f_claim & st.fox_latch);

	// direction bits alone pick latch or pin on reads
	assign e_rd = (st.east_dir & st.east_latch) | (~st.east_dir & east_pin_in);
	assign f_rd = (st.fox_dir & st.fox_latch) | (~st.fox_dir & fox_pin_in);

	assign idx = paddr[9:2];
	assign hit = (idx == `GEF_IDX_E_DATA) || (idx == `GEF_IDX_F_DATA) ||
		(idx == `GEF_IDX_E_DIR) || (idx == `GEF_IDX_F_DIR);
	assign wr_ok = pwrite & hit & pstrb[0];

	always_comb begin
		unique case (idx)
			`GEF_IDX_E_DATA: rd_word = {24'h00_0000, e_rd};
			`GEF_IDX_F_DATA: rd_word = {25'h000_0000, f_rd};
			`GEF_IDX_E_DIR:  rd_word = {24'h00_0000, st.east_dir};
			`GEF_IDX_F_DIR:  rd_word = {25'h000_0000, st.fox_dir};
			default:         rd_word = `GEF_RD_RST;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.east_lvl = east_pin_in;
		next_st.fox_lvl = fox_pin_in;
		// non-driven pins park low so no unknown reaches the pad
		next_st.east_out = e_val & e_drv;
		next_st.east_oe_n = ~e_drv;
		next_st.fox_out = f_val & f_drv;
		next_st.fox_oe_n = ~f_drv;
		unique case (st.bus)
			GEF_WAIT: begin
				if (psel && penable) begin
					next_st.bus = GEF_ACK;
					next_st.slverr = ~hit;
					next_st.rdata = pwrite ? `GEF_RD_RST : rd_word;
				end
			end
			GEF_ACK: begin
				next_st.bus = GEF_WAIT;
				next_st.slverr = 1'b0;
				if (psel && penable && wr_ok) begin
					unique case (idx)
						`GEF_IDX_E_DATA: next_st.east_latch = pwdata[7:0];
						`GEF_IDX_F_DATA: next_st.fox_latch = pwdata[6:0];
						`GEF_IDX_E_DIR:  next_st.east_dir = pwdata[7:0];
						`GEF_IDX_F_DIR:  next_st.fox_dir = pwdata[6:0];
						default:         next_st.east_dir = st.east_dir;
					endcase
				end
			end
		endcase
		if (!ce) begin
			next_st = st;
		end
	end

	// the data latches have no reset term
	always_ff @(posedge clk or negedge rst_q) begin
		if (!rst_q) begin
			st.east_dir <= `GEF_E_DIR_RST;
			st.fox_dir <= `GEF_F_DIR_RST;
			st.east_out <= `GEF_E_OUT_RST;
			st.east_oe_n <= `GEF_E_OEN_RST;
			st.east_lvl <= `GEF_E_OUT_RST;
			st.fox_out <= `GEF_F_OUT_RST;
			st.fox_oe_n <= `GEF_F_OEN_RST;
			st.fox_lvl <= `GEF_F_OUT_RST;
			st.bus <= GEF_WAIT;
			st.rdata <= `GEF_RD_RST;
			st.slverr <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.rdata;
	assign pready = (st.bus == GEF_ACK);
	assign pslverr = st.slverr;
	assign east_pin_out = st.east_out;
	assign east_pin_oe_n = st.east_oe_n;
	assign east_pin_level = st.east_lvl;
	assign fox_pin_out = st.fox_out;
	assign fox_pin_oe_n = st.fox_oe_n;
	assign fox_pin_level = st.fox_lvl;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_q);

	sequence s_rd_req(logic [7:0] ix);
		ce && psel && penable && !pwrite && (st.bus == GEF_WAIT) && (idx == ix);
	endsequence

	sequence s_wr_done(logic [7:0] ix);
		ce && psel && penable && pwrite && pready && pstrb[0] && (idx == ix);
	endsequence

	sequence s_acc;
		ce && psel && penable && (st.bus == GEF_WAIT);
	endsequence

	AST_DIR_RESET: assert property (
		$rose(rst_q) |-> (st.east_dir == `GEF_E_DIR_RST) && (st.fox_dir == `GEF_F_DIR_RST))
		else $error("direction bits not cleared by reset");

	AST_E_READ: assert property (
		s_rd_req(`GEF_IDX_E_DATA) |=> pready && (prdata[31:8] == '0) &&
		(prdata[7:0] == $past((st.east_dir & st.east_latch) | (~st.east_dir & east_pin_in))))
		else $error("east read does not mix latch and pin by direction");

	AST_F_READ: assert property (
		s_rd_req(`GEF_IDX_F_DATA) |=> pready && (prdata[31:7] == '0) &&
		(prdata[6:0] == $past((st.fox_dir & st.fox_latch) | (~st.fox_dir & fox_pin_in))))
		else $error("fox read wrong");

	AST_LATCH_WRITE: assert property (
		s_wr_done(`GEF_IDX_E_DATA) |=> (st.east_latch == $past(pwdata[7:0])))
		else $error("east latch write lost");

	AST_E_GPIO: assert property (
		ce && !async_serial_on && st.east_dir[0] |=>
		!east_pin_oe_n[0] && (east_pin_out[0] == $past(st.east_latch[0])))
		else $error("east gpio output not driving latch");

	AST_E_SCK: assert property (
		ce && sync_serial_on |=> (east_pin_oe_n[7] == !$past(sync_serial_master)))
		else $error("serial clock direction wrong");

	AST_E_MISO: assert property (
		ce && sync_serial_on |=> (east_pin_oe_n[5] == $past(sync_serial_master)))
		else $error("miso direction wrong");

	AST_E_SS: assert property (
		ce && sync_serial_on && !sync_serial_master |=> east_pin_oe_n[4])
		else $error("slave select driven in slave mode");

	AST_E_TIMER: assert property (
		ce && ta_own[0] |=> (east_pin_oe_n[2] == !$past(timer_a_chan_oe[0])))
		else $error("timer A channel 0 direction wrong");

	AST_E_SCI: assert property (
		ce && async_serial_on |=> east_pin_oe_n[1] && !east_pin_oe_n[0] &&
		(east_pin_out[0] == $past(async_serial_tx_out)))
		else $error("async serial pins wrong");

	AST_F_TA: assert property (
		ce && ta_own[5] |=> (fox_pin_oe_n[3] == !$past(timer_a_chan_oe[5])))
		else $error("timer A channel 5 direction wrong");

	AST_F_TB: assert property (
		ce && tb_own[1] |=> (fox_pin_oe_n[5] == !$past(timer_b_chan_oe[1])))
		else $error("timer B channel 1 direction wrong");

	AST_F_GPIO: assert property (
		ce && st.fox_dir[6] |=> !fox_pin_oe_n[6])
		else $error("fox gpio output disabled");

	AST_FREEZE: assert property (
		!ce |=> $stable(st))
		else $error("state moved while clock enable low");

	AST_E_MOSI: assert property (
		ce && sync_serial_on |=> (east_pin_oe_n[6] == !$past(sync_serial_master)))
		else $error("mosi direction wrong");

	AST_E_SCK_OUT: assert property (
		ce && sync_serial_on && sync_serial_master |=>
		!east_pin_oe_n[7] && (east_pin_out[7] == $past(sync_serial_clk_out)))
		else $error("master serial clock not driven");

	AST_E_SS_GPIO: assert property (
		ce && sync_serial_on && sync_serial_master |=>
		(east_pin_oe_n[4] == !$past(st.east_dir[4])))
		else $error("slave select pin not gpio in master mode");

	AST_E_RXD: assert property (
		ce && async_serial_on |=> east_pin_oe_n[1] && !east_pin_out[1])
		else $error("receive pin driven");

	AST_E_TIMER1: assert property (
		ce && ta_own[1] |=> (east_pin_oe_n[3] == !$past(timer_a_chan_oe[1])))
		else $error("timer A channel 1 direction wrong");

	AST_E_OWN_DIR: assert property (
		ce && ta_own[1] && !timer_a_chan_oe[1] |=> east_pin_oe_n[3])
		else $error("direction bit overrode timer on east pin");

	AST_F_TA_LOW: assert property (
		ce && ta_own[2] |=> (fox_pin_oe_n[0] == !$past(timer_a_chan_oe[2])) &&
		(fox_pin_out[0] == $past(timer_a_chan_oe[2] && timer_a_chan_out[2])))
		else $error("timer A channel 2 pin wrong");

	AST_F_TB0: assert property (
		ce && tb_own[0] |=> (fox_pin_oe_n[4] == !$past(timer_b_chan_oe[0])))
		else $error("timer B channel 0 direction wrong");

	AST_F_OWN_DIR: assert property (
		ce && tb_own[1] && !timer_b_chan_oe[1] |=> fox_pin_oe_n[5])
		else $error("direction bit overrode timer on fox pin");

	AST_F_LATCH_WRITE: assert property (
		s_wr_done(`GEF_IDX_F_DATA) |=> (st.fox_latch == $past(pwdata[6:0])))
		else $error("fox latch write lost");

	AST_E_DIR_WRITE: assert property (
		s_wr_done(`GEF_IDX_E_DIR) |=> (st.east_dir == $past(pwdata[7:0])))
		else $error("east direction write lost");

	AST_F_DIR_WRITE: assert property (
		s_wr_done(`GEF_IDX_F_DIR) |=> (st.fox_dir == $past(pwdata[6:0])))
		else $error("fox direction write lost");

	AST_PIN_RESET: assert property (
		$rose(rst_q) |-> (east_pin_oe_n == `GEF_E_OEN_RST) &&
		(fox_pin_oe_n == `GEF_F_OEN_RST))
		else $error("pins not released by reset");

	AST_ANSWER: assert property (
		s_acc |=> pready)
		else $error("access phase not answered");

	AST_PREADY_PULSE: assert property (
		ce && pready |=> !pready)
		else $error("ready longer than one cycle");

	AST_SLVERR: assert property (
		s_acc ##0 !hit |=> pslverr && (prdata == `GEF_RD_RST))
		else $error("unmapped access not flagged");

	AST_SLVERR_READY: assert property (
		pslverr |-> pready)
		else $error("error flag without ready");

	AST_STRB_GATE: assert property (
		ce && psel && penable && pready && !pstrb[0] |=>
		$stable(st.east_dir) && $stable(st.fox_dir))
		else $error("write landed with strobe low");

	AST_LEVEL: assert property (
		ce |=> (east_pin_level == $past(east_pin_in)) && (fox_pin_level == $past(fox_pin_in)))
		else $error("pin level not one cycle behind pin");

endmodule

`default_nettype wire

// ### gef_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module gef_pin_model #(parameter int W = 8)
(
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe_n,
	input  wire logic [W-1:0] ext_drive,
	output logic      [W-1:0] pin_in
);
	// a pin shows the port drive when enabled, else the outside driver
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pin_in[i] = pin_oe_n[i] ? ext_drive[i] : pin_out[i];
		end
	end
endmodule

`default_nettype wire

// ### shared_gpio_ports_e_f_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "gef_regs.svh"

module shared_gpio_ports_e_f_test;
	logic        clk, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [9:0]  paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic        pready, pslverr;
	logic [7:0]  e_in, e_out, e_oen, ext_e = 0;
	logic [6:0]  f_in, f_out, f_oen, ext_f = 0;
	logic        sso = 0, ssm = 0, ssc = 0, ssmo = 0, ssmi = 0, aso = 0, atx = 0;
	logic [11:0] ta_sel = 0;
	logic [5:0]  ta_oe = 0, ta_out = 0;
	logic [3:0]  tb_sel = 0;
	logic [1:0]  tb_oe = 0, tb_out = 0;
	logic        ce = 1;
	logic [3:0]  strb = 4'hf;
	logic [7:0]  e_lvl;
	logic [6:0]  f_lvl;
	int          errors = 0, n_tests = 0;

	gef_ports dut (.clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.east_pin_in(e_in), .east_pin_out(e_out), .east_pin_oe_n(e_oen),
		.east_pin_level(e_lvl), .fox_pin_in(f_in), .fox_pin_out(f_out),
		.fox_pin_oe_n(f_oen), .fox_pin_level(f_lvl), .sync_serial_on(sso),
		.sync_serial_master(ssm), .sync_serial_clk_out(ssc),
		.sync_serial_mosi_out(ssmo), .sync_serial_miso_out(ssmi),
		.async_serial_on(aso), .async_serial_tx_out(atx),
		.timer_a_chan_edge_level_sel(ta_sel), .timer_a_chan_oe(ta_oe),
		.timer_a_chan_out(ta_out), .timer_b_chan_edge_level_sel(tb_sel),
		.timer_b_chan_oe(tb_oe), .timer_b_chan_out(tb_out));
	gef_pin_model #(.W(8)) east_side (.pin_out(e_out), .pin_oe_n(e_oen),
		.ext_drive(ext_e), .pin_in(e_in));
	gef_pin_model #(.W(7)) fox_side (.pin_out(f_out), .pin_oe_n(f_oen),
		.ext_drive(ext_f), .pin_in(f_in));

	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end

	task finish_test;
		if (errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task apb(input logic w, input logic [7:0] i, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		// one idle edge so the next transfer never reassigns psel in this step
		@(posedge clk);
	endtask

	task wr(input logic [7:0] i, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1, i, d, r, e);
	endtask

	task rd(input logic [7:0] i, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(0, i, 0, r, e);
		chk(r, x);
	endtask

	task do_reset;
		reset_n <= 0;
		cyc(16);
		reset_n <= 1;
		cyc(3);
	endtask

	task t_reset;
		chk(e_oen, 8'hff);
		chk(f_oen, 7'h7f);
		rd(`GEF_IDX_E_DIR, 0);
		rd(`GEF_IDX_F_DIR, 0);
	endtask

	task t_east;
		ext_e <= 8'h3c;
		wr(`GEF_IDX_E_DATA, 8'ha5);
		cyc(2);
		chk(e_oen, 8'hff);
		rd(`GEF_IDX_E_DATA, 8'h3c);
		wr(`GEF_IDX_E_DIR, 8'h0f);
		cyc(2);
		chk({e_oen, e_out}, 16'hf005);
		rd(`GEF_IDX_E_DATA, 8'h35);
	endtask

	task t_fox;
		ext_f <= 7'h55;
		wr(`GEF_IDX_F_DATA, 8'hff);
		rd(`GEF_IDX_F_DATA, 8'h55);
		wr(`GEF_IDX_F_DIR, 8'hff);
		rd(`GEF_IDX_F_DIR, 8'h7f);
		rd(`GEF_IDX_F_DATA, 8'h7f);
		chk({f_oen, f_out}, 14'h007f);
		wr(`GEF_IDX_F_DATA, 8'h12);
		do_reset;
		chk(f_oen, 7'h7f);
		wr(`GEF_IDX_F_DIR, 8'h7f);
		rd(`GEF_IDX_F_DATA, 8'h12);
	endtask

	task t_serial;
		wr(`GEF_IDX_E_DATA, 8'h00);
		wr(`GEF_IDX_E_DIR, 8'h10);
		{sso, ssm, ssc, ssmo, ssmi} <= 5'h1f;
		cyc(2);
		chk({e_oen, e_out[7:6]}, 10'h0bf);
		ssm <= 0;
		wr(`GEF_IDX_E_DIR, 8'h10);
		cyc(2);
		chk({e_oen, e_out[5]}, 9'h1bf);
		sso <= 0;
		cyc(2);
		chk(e_oen, 8'hef);
		{aso, atx} <= 2'b11;
		wr(`GEF_IDX_E_DIR, 8'h02);
		cyc(2);
		chk({e_oen, e_out[0]}, 9'h1fd);
		aso <= 0;
		cyc(2);
		chk(e_oen, 8'hfd);
	endtask

	task t_timer;
		ext_e <= 8'hc3;
		ext_f <= 7'h7f;
		ta_sel <= 12'h555;
		ta_oe <= 6'h3d;
		ta_out <= 6'h2a;
		tb_sel <= 4'h5;
		{tb_oe, tb_out} <= 4'b0101;
		wr(`GEF_IDX_E_DATA, 8'h04);
		wr(`GEF_IDX_E_DIR, 8'h0c);
		wr(`GEF_IDX_F_DIR, 8'h20);
		cyc(2);
		chk({e_oen, e_out[2]}, 9'h1f6);
		chk({f_oen, f_out[4:0]}, 12'hc1a);
		rd(`GEF_IDX_E_DATA, 8'hc7);
		rd(`GEF_IDX_F_DATA, 8'h5a);
		ta_sel <= 0;
		tb_sel <= 0;
		cyc(2);
		chk({e_oen, f_oen}, 15'h79df);
	endtask

	task t_freeze;
		ce <= 0;
		aso <= 1;
		ext_e <= 8'h5a;
		cyc(3);
		chk(e_oen, 8'hf3);
		chk(e_lvl, 8'hc7);
		chk(f_lvl, 7'h5f);
		ce <= 1;
		cyc(2);
		chk(e_oen, 8'hf2);
		chk(e_lvl, 8'h56);
		aso <= 0;
	endtask

	task t_bus;
		logic [31:0] r;
		logic        e;
		strb <= 4'he;
		apb(0, 8'h0a, 0, r, e);
		chk(r, 0);
		chk(e, 1);
		wr(`GEF_IDX_E_DIR, 8'hff);
		strb <= 4'hf;
		rd(`GEF_IDX_E_DIR, 8'h0c);
	endtask

	initial begin
		do_reset;
		t_reset;
		t_east;
		t_fox;
		t_serial;
		t_timer;
		t_freeze;
		t_bus;
		finish_test;
	end

	initial begin
		#500000;
		errors++;
		finish_test;
	end
endmodule

`default_nettype wire
